/* File: core/pgu_regs.vh */
// Field positions, exception vectors and sizes of the page translation unit
//----------------------------------------------------------------------
// Operation
//----------------------------------------------------------------------
`ifndef PGU_REGS_VH
`define PGU_REGS_VH

//----------------------------------------------------------------------
// Entry fields
//----------------------------------------------------------------------
`define ENT_P       0
`define ENT_RW      1
`define ENT_US      2
`define ENT_A       5
`define ENT_D       6

//----------------------------------------------------------------------
// Error code fields and vectors
//----------------------------------------------------------------------
`define EC_P        0
`define EC_WR       1
`define EC_US       2
`define VEC_PF      8'h0E
`define VEC_GP      8'h0D

//----------------------------------------------------------------------
// Sizes
//----------------------------------------------------------------------
`define TLB_N       32
`define TLB_IW      5
`define V86_TOP     20

`endif

/* File: core/v86_addr_form.v */
// Linear address former for protected and virtual-8086 addressing
`timescale 1ns/1ns
`include "pgu_regs.vh"
module v86_addr_form (
    input  wire        v86_i,
    input  wire [15:0] seg_i,
    input  wire [31:0] off_i,
    output wire [31:0] lin_o,
    output wire        over_o
);
    wire [32:0] sum;

    //------------------------------------------------------------------
    // Segment base is paragraph aligned
    //------------------------------------------------------------------
    assign sum    = {13'h0000, seg_i, 4'h0} + {1'b0, off_i};
    assign lin_o  = v86_i ? sum[31:0] : off_i;
    assign over_o = v86_i && (sum[32:`V86_TOP] != 13'h0000);
endmodule // v86_addr_form

/* File: core/paging_translation_unit.v */
// Page translation unit: cache lookup, table walk, faults
`timescale 1ns/1ns
`include "pgu_regs.vh"
module paging_translation_unit (
    input  wire        mclk_i,
    input  wire        rst_b_i,
    input  wire        paging_en_i,
    input  wire        dir_base_wr_i,
    input  wire        task_switch_i,
    input  wire [31:0] dir_base_i,
    output reg  [31:0] dir_base_o,
    input  wire        req_valid_i,
    output wire        req_ready_o,
    input  wire        req_v86_i,
    input  wire [15:0] req_seg_i,
    input  wire [31:0] req_off_i,
    input  wire        req_write_i,
    input  wire        req_user_i,
    input  wire        req_sys_i,
    input  wire [31:0] req_ip_i,
    output reg         done_o,
    output reg  [23:0] phys_o,
    output reg         fault_o,
    output reg  [7:0]  fault_vec_o,
    output reg  [15:0] err_code_o,
    output reg  [31:0] fault_addr_o,
    output reg  [31:0] saved_ip_o,
    output reg         mem_req_o,
    output reg         mem_write_o,
    output reg         mem_lock_o,
    output reg  [23:0] mem_addr_o,
    output reg  [31:0] mem_wdata_o,
    input  wire        mem_ack_i,
    input  wire [31:0] mem_rdata_i
);
    //------------------------------------------------------------------
    // States
    //------------------------------------------------------------------
    localparam [2:0] S_IDLE   = 3'h0;
    localparam [2:0] S_LOOK   = 3'h1;
    localparam [2:0] S_PDE_RD = 3'h2;
    localparam [2:0] S_PDE_WR = 3'h3;
    localparam [2:0] S_PTE_RD = 3'h4;
    localparam [2:0] S_PTE_WR = 3'h5;

    //------------------------------------------------------------------
    // First set bit of a 32-bit vector
    //------------------------------------------------------------------
    function [`TLB_IW-1:0] first_set;
        input [`TLB_N-1:0] v;
        integer k;
        begin
            first_set = {`TLB_IW{1'b0}};
            for (k = `TLB_N - 1; k >= 0; k = k - 1)
                if (v[k])
                    first_set = k[`TLB_IW-1:0];
        end
    endfunction

    reg  [2:0]          state_q;
    reg  [31:0]         lin_q;
    reg                 over_q;
    reg                 write_q;
    reg                 user_q;
    reg                 v86_q;
    reg  [31:0]         ip_q;
    reg  [31:0]         pde_q;
    reg  [31:0]         pte_q;
    reg  [`TLB_N-1:0]   valid_q;
    reg  [19:0]         vpn_q   [0:`TLB_N-1];
    reg  [11:0]         frame_q [0:`TLB_N-1];
    reg  [`TLB_N-1:0]   us_q;
    reg  [`TLB_N-1:0]   rw_q;
    reg  [`TLB_N-1:0]   dirty_q;
    reg  [`TLB_IW-1:0]  rr_q;
    reg                 install;
    wire [31:0]         lin_w;
    wire                over_w;
    wire [`TLB_N-1:0]   hit_vec;
    wire                hit;
    wire [`TLB_IW-1:0]  hit_idx;
    wire [`TLB_IW-1:0]  victim;
    wire [`TLB_IW-1:0]  inst_idx;
    wire                flush;
    wire                eff_us;
    wire                eff_rw;
    wire                prot_bad;
    wire                hit_bad;
    wire [31:0]         pte_upd;
    wire [31:0]         pde_rd_addr;
    wire [31:0]         pte_rd_addr;
    wire [31:0]         pte_cur;

    //------------------------------------------------------------------
    // Address forming
    //------------------------------------------------------------------
    v86_addr_form u_form (
        .v86_i  (req_v86_i),
        .seg_i  (req_seg_i),
        .off_i  (req_off_i),
        .lin_o  (lin_w),
        .over_o (over_w)
    );

    assign req_ready_o = (state_q == S_IDLE);
    assign flush       = dir_base_wr_i | task_switch_i;

    //------------------------------------------------------------------
    // Cache lookup
    //------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `TLB_N; g = g + 1)
        begin : g_cmp
            assign hit_vec[g] = valid_q[g] &&
                                (vpn_q[g] == lin_q[31:12]);
        end
    endgenerate

    assign hit     = |hit_vec;
    assign hit_idx = first_set(hit_vec);
    // Empty slot first, else round robin, so refills stay predictable
    assign victim   = (&valid_q) ? rr_q : first_set(~valid_q);
    assign inst_idx = hit ? hit_idx : victim;
    // A hit that needs the dirty flag set is refetched through the walk
    assign hit_bad  = user_q && (!us_q[hit_idx] ||
                      (write_q && !rw_q[hit_idx]));

    //------------------------------------------------------------------
    // Walk helpers
    //------------------------------------------------------------------
    assign pde_rd_addr = {dir_base_o[31:12], lin_q[31:22], 2'b00};
    assign pte_rd_addr = {pde_q[31:12], lin_q[21:12], 2'b00};
    assign eff_us   = pde_q[`ENT_US] & mem_rdata_i[`ENT_US];
    assign eff_rw   = pde_q[`ENT_RW] & mem_rdata_i[`ENT_RW];
    assign prot_bad = user_q && (!eff_us || (write_q && !eff_rw));
    assign pte_upd  = mem_rdata_i | (32'h1 << `ENT_A) |
                      ((write_q ? 32'h1 : 32'h0) << `ENT_D);
    // An install on the table read itself has no registered entry yet
    assign pte_cur  = (state_q == S_PTE_RD) ? pte_upd : pte_q;

    //------------------------------------------------------------------
    // Translation cache store
    //------------------------------------------------------------------
    // A flush in the same cycle as an install wins: the walk was made
    // against the old directory and must not survive the reload.
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            valid_q <= {`TLB_N{1'b0}};
            us_q    <= {`TLB_N{1'b0}};
            rw_q    <= {`TLB_N{1'b0}};
            dirty_q <= {`TLB_N{1'b0}};
            rr_q    <= {`TLB_IW{1'b0}};
        end
        else if (flush)
        begin
            valid_q <= {`TLB_N{1'b0}};
        end
        else if (install)
        begin
            valid_q[inst_idx] <= 1'b1;
            us_q[inst_idx]    <= pde_q[`ENT_US] & pte_cur[`ENT_US];
            rw_q[inst_idx]    <= pde_q[`ENT_RW] & pte_cur[`ENT_RW];
            dirty_q[inst_idx] <= pte_cur[`ENT_D];
            if (!hit && (&valid_q))
                rr_q <= rr_q + 5'h01;
        end
    end

    always @(posedge mclk_i)
    begin
        if (install && !flush)
        begin
            vpn_q[inst_idx]   <= lin_q[31:12];
            frame_q[inst_idx] <= pte_cur[23:12];
        end
    end

    //------------------------------------------------------------------
    // Install strobe
    //------------------------------------------------------------------
    always @*
    begin
        install = 1'b0;
        if (state_q == S_PTE_RD && mem_ack_i && mem_rdata_i[`ENT_P] &&
            !prot_bad && mem_rdata_i[`ENT_A] &&
            !(write_q && !mem_rdata_i[`ENT_D]))
            install = 1'b1;
        if (state_q == S_PTE_WR && mem_ack_i)
            install = 1'b1;
    end

    //------------------------------------------------------------------
    // Control and walk
    //------------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q      <= S_IDLE;
            lin_q        <= 32'h00000000;
            over_q       <= 1'b0;
            write_q      <= 1'b0;
            user_q       <= 1'b0;
            v86_q        <= 1'b0;
            ip_q         <= 32'h00000000;
            pde_q        <= 32'h00000000;
            pte_q        <= 32'h00000000;
            dir_base_o   <= 32'h00000000;
            done_o       <= 1'b0;
            phys_o       <= 24'h000000;
            fault_o      <= 1'b0;
            fault_vec_o  <= 8'h00;
            err_code_o   <= 16'h0000;
            fault_addr_o <= 32'h00000000;
            saved_ip_o   <= 32'h00000000;
            mem_req_o    <= 1'b0;
            mem_write_o  <= 1'b0;
            mem_lock_o   <= 1'b0;
            mem_addr_o   <= 24'h000000;
            mem_wdata_o  <= 32'h00000000;
        end
        else
        begin
            done_o  <= 1'b0;
            fault_o <= 1'b0;
            if (flush)
                dir_base_o <= {dir_base_i[31:12], 12'h000};
            case (state_q)
                S_IDLE:
                begin
                    if (req_valid_i)
                    begin
                        lin_q   <= lin_w;
                        over_q  <= over_w;
                        write_q <= req_write_i;
                        // Virtual-8086 code runs at user level unless req_sys_i marks a system access
                        user_q  <= (req_user_i | req_v86_i) &
                                   !req_sys_i;
                        v86_q   <= req_v86_i;
                        ip_q    <= req_ip_i;
                        state_q <= S_LOOK;
                    end
                end
                S_LOOK:
                begin
                    if (over_q)
                    begin
                        fault_o     <= 1'b1;
                        fault_vec_o <= `VEC_GP;
                        saved_ip_o  <= ip_q;
                        state_q     <= S_IDLE;
                    end
                    else if (!paging_en_i)
                    begin
                        phys_o  <= lin_q[23:0];
                        done_o  <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else if (hit && hit_bad)
                    begin
                        fault_o      <= 1'b1;
                        fault_vec_o  <= `VEC_PF;
                        err_code_o   <= {13'h0000, user_q, write_q,
                                         1'b1};
                        fault_addr_o <= lin_q;
                        saved_ip_o   <= ip_q;
                        state_q      <= S_IDLE;
                    end
                    else if (hit && !(write_q && !dirty_q[hit_idx]))
                    begin
                        phys_o  <= {frame_q[hit_idx], lin_q[11:0]};
                        done_o  <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else
                    begin
                        mem_req_o   <= 1'b1;
                        mem_write_o <= 1'b0;
                        mem_lock_o  <= 1'b1;
                        mem_addr_o  <= pde_rd_addr[23:0];
                        state_q     <= S_PDE_RD;
                    end
                end
                S_PDE_RD:
                begin
                    if (mem_ack_i)
                    begin
                        pde_q <= mem_rdata_i;
                        if (!mem_rdata_i[`ENT_P])
                        begin
                            mem_req_o    <= 1'b0;
                            mem_lock_o   <= 1'b0;
                            fault_o      <= 1'b1;
                            fault_vec_o  <= `VEC_PF;
                            err_code_o   <= {13'h0000, user_q, write_q,
                                             1'b0};
                            fault_addr_o <= lin_q;
                            saved_ip_o   <= ip_q;
                            state_q      <= S_IDLE;
                        end
                        else if (!mem_rdata_i[`ENT_A])
                        begin
                            mem_write_o <= 1'b1;
                            mem_wdata_o <= mem_rdata_i |
                                           (32'h1 << `ENT_A);
                            state_q     <= S_PDE_WR;
                        end
                        else
                        begin
                            mem_addr_o <= {mem_rdata_i[23:12],
                                           lin_q[21:12], 2'b00};
                            state_q    <= S_PTE_RD;
                        end
                    end
                end
                S_PDE_WR:
                begin
                    if (mem_ack_i)
                    begin
                        mem_write_o <= 1'b0;
                        mem_addr_o  <= pte_rd_addr[23:0];
                        state_q     <= S_PTE_RD;
                    end
                end
                S_PTE_RD:
                begin
                    if (mem_ack_i)
                    begin
                        pte_q <= pte_upd;
                        if (!mem_rdata_i[`ENT_P] || prot_bad)
                        begin
                            mem_req_o    <= 1'b0;
                            mem_lock_o   <= 1'b0;
                            fault_o      <= 1'b1;
                            fault_vec_o  <= `VEC_PF;
                            err_code_o   <= {13'h0000, user_q, write_q,
                                             mem_rdata_i[`ENT_P]};
                            fault_addr_o <= lin_q;
                            saved_ip_o   <= ip_q;
                            state_q      <= S_IDLE;
                        end
                        else if (!install)
                        begin
                            mem_write_o <= 1'b1;
                            mem_wdata_o <= pte_upd;
                            state_q     <= S_PTE_WR;
                        end
                        else
                        begin
                            mem_req_o  <= 1'b0;
                            mem_lock_o <= 1'b0;
                            phys_o     <= {mem_rdata_i[23:12],
                                           lin_q[11:0]};
                            done_o     <= 1'b1;
                            state_q    <= S_IDLE;
                        end
                    end
                end
                S_PTE_WR:
                begin
                    if (mem_ack_i)
                    begin
                        mem_req_o   <= 1'b0;
                        mem_write_o <= 1'b0;
                        mem_lock_o  <= 1'b0;
                        phys_o      <= {pte_q[23:12], lin_q[11:0]};
                        done_o      <= 1'b1;
                        state_q     <= S_IDLE;
                    end
                end
                default:
                begin
                    mem_req_o  <= 1'b0;
                    mem_lock_o <= 1'b0;
                    state_q    <= S_IDLE;
                end
            endcase
        end
    end
endmodule // paging_translation_unit

/* File: tb/pgu_mem_model.sv */
// Memory partner holding directory and table entries
`timescale 1ns/1ns
module pgu_mem_model (
    input  wire        mclk_i,
    input  wire        mem_req_i,
    input  wire        mem_write_i,
    input  wire [23:0] mem_addr_i,
    input  wire [31:0] mem_wdata_i,
    input  wire [1:0]  delay_i,
    output reg         mem_ack_o,
    output reg  [31:0] mem_rdata_o
);
    logic [31:0] mem [int];
    int          cnt = 0;
    initial mem_ack_o = 1'h0;
    initial mem_rdata_o = 32'h0;
    // Read data is scrambled outside an answer so stale values never pass
    always @(posedge mclk_i)
    begin
        mem_ack_o <= 1'h0;
        mem_rdata_o <= ~mem_rdata_o;
        if (mem_req_i && !mem_ack_o)
        begin
            if (cnt < delay_i)
                cnt <= cnt + 1;
            else
            begin
                cnt <= 0;
                mem_ack_o <= 1'h1;
                if (mem_write_i)
                    mem[mem_addr_i] = mem_wdata_i;
                else
                    mem_rdata_o <= mem.exists(mem_addr_i) ?
                                   mem[mem_addr_i] : 32'h0;
            end
        end
    end
endmodule // pgu_mem_model

/* File: tb/pgu_checker.sv */
// Port assertions for the page translation unit
`timescale 1ns/1ns
module pgu_checker (
    input wire        mclk_i,
    input wire        rst_b_i,
    input wire        paging_en_i,
    input wire        dir_base_wr_i,
    input wire        task_switch_i,
    input wire [31:0] dir_base_i,
    input wire [31:0] dir_base_o,
    input wire        req_valid_i,
    input wire        req_ready_o,
    input wire        req_v86_i,
    input wire [15:0] req_seg_i,
    input wire [31:0] req_off_i,
    input wire        req_write_i,
    input wire        req_user_i,
    input wire        req_sys_i,
    input wire [31:0] req_ip_i,
    input wire        done_o,
    input wire [23:0] phys_o,
    input wire        fault_o,
    input wire [7:0]  fault_vec_o,
    input wire [15:0] err_code_o,
    input wire [31:0] fault_addr_o,
    input wire [31:0] saved_ip_o,
    input wire        mem_req_o,
    input wire        mem_write_o,
    input wire        mem_lock_o,
    input wire [23:0] mem_addr_o,
    input wire [31:0] mem_wdata_o,
    input wire        mem_ack_i
);
    wire        take = req_valid_i && req_ready_o;
    wire [31:0] lin  = req_v86_i ? {12'h000, req_seg_i, 4'h0} + req_off_i
                                 : req_off_i;
    reg  [31:0] lin_q;
    reg  [31:0] ip_q;
    reg  [1:0]  acc_q;
    reg  [19:0] nb_q;
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lin_q <= 32'h0;
            ip_q <= 32'h0;
            acc_q <= 2'h0;
            nb_q <= 20'h0;
        end
        else
        begin
            nb_q <= dir_base_i[31:12];
            if (take)
            begin
                lin_q <= lin;
                ip_q <= req_ip_i;
                acc_q <= {(req_user_i | req_v86_i) & !req_sys_i, req_write_i};
            end
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    a_off_direct: assert property (take && !paging_en_i && !req_v86_i |=>
        !mem_req_o ##1 (done_o && phys_o == lin_q[23:0]))
        else $error("paging off result wrong");
    a_over_fault: assert property (take && req_v86_i && lin[31:20] != 0 |=>
        !done_o ##1 (fault_o && fault_vec_o == 8'h0D && !mem_req_o))
        else $error("v86 limit fault missing");
    a_dir_first: assert property ($rose(mem_lock_o) |-> mem_req_o &&
        !mem_write_o && mem_addr_o == {dir_base_o[23:12], lin_q[31:22], 2'h0})
        else $error("walk did not start at directory");
    a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
        $stable(mem_addr_o) && $stable(mem_wdata_o))
        else $error("memory request changed before ack");
    a_req_locked: assert property (mem_req_o |-> mem_lock_o)
        else $error("memory access without lock");
    a_lock_end: assert property ($fell(mem_lock_o) |-> $past(mem_ack_i))
        else $error("lock dropped without ack");
    a_flag_set: assert property (mem_req_o && mem_write_o |-> mem_wdata_o[5])
        else $error("entry written back without accessed flag");
    a_fault_addr: assert property (fault_o && fault_vec_o == 8'h0E |->
        fault_addr_o == lin_q)
        else $error("fault address wrong");
    a_err_bits: assert property (fault_o && fault_vec_o == 8'h0E |->
        err_code_o[15:1] == {13'h0, acc_q})
        else $error("error code wrong");
    a_saved_ip: assert property (fault_o |-> saved_ip_o == ip_q)
        else $error("saved pointer wrong");
    a_base_flush: assert property (dir_base_wr_i || task_switch_i |=>
        dir_base_o == {nb_q, 12'h000})
        else $error("directory base not loaded");
    c_dirty: cover property (mem_req_o && mem_write_o && mem_wdata_o[6]);
    c_prot: cover property (fault_o && err_code_o[0]);
    c_over: cover property (fault_o && fault_vec_o == 8'h0D);
endmodule // pgu_checker
bind paging_translation_unit pgu_checker chk (.*);

/* File: tb/tb_paging_translation_unit.sv */
// Self-checking bench for the page translation unit
`timescale 1ns/1ns
module tb_paging_translation_unit;
    logic        mclk_i = 1'h0, rst_b_i = 1'h0, paging_en_i = 1'h0;
    logic        dir_base_wr_i = 1'h0, task_switch_i = 1'h0;
    logic        req_valid_i = 1'h0, req_v86_i = 1'h0, req_write_i = 1'h0;
    logic        req_user_i = 1'h0, req_sys_i = 1'h0;
    logic [15:0] req_seg_i = 16'h0;
    logic [31:0] req_off_i = 32'h0, req_ip_i = 32'h0, dir_base_i = 32'h0;
    logic [1:0]  delay = 2'h0;
    logic [23:0] dbase = 24'h001000;
    wire  [31:0] dir_base_o, fault_addr_o, saved_ip_o, mem_wdata_o, mem_rdata_i;
    wire  [23:0] phys_o, mem_addr_o;
    wire  [15:0] err_code_o;
    wire  [7:0]  fault_vec_o;
    wire         req_ready_o, done_o, fault_o, mem_req_o, mem_write_o;
    wire         mem_lock_o, mem_ack_i;
    int          err_total = 0, total_checks = 0, walks, p, k;
    logic [31:0] pg [5] = '{32'h00403000, 32'h00405000, 32'h00800000,
                            32'h00C01000, 32'h00407000};
    always #25 mclk_i = ~mclk_i;
    paging_translation_unit uut (.*);
    pgu_mem_model mem_m (.mclk_i(mclk_i), .mem_req_i(mem_req_o),
        .mem_write_i(mem_write_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .delay_i(delay), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i));
    //------------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [31:0] rd(input logic [23:0] a);
        return mem_m.mem.exists(a) ? mem_m.mem[a] : 32'h0;
    endfunction
    // One table per directory slot; tables placed above the directories
    task automatic map(input logic [31:0] lin, input logic [11:0] fr,
                       input logic [2:0] df, tf);
        logic [11:0] t;
        t = 12'h010 + {2'h0, lin[31:22]};
        mem_m.mem[{dbase[23:12], lin[31:22], 2'h0}] = {8'h0, t, 9'h0, df};
        mem_m.mem[{t, lin[21:12], 2'h0}] = {8'h0, fr, 9'h0, tf};
    endtask
    task automatic load_base(input bit ts, input logic [23:0] b);
        dbase = b;
        dir_base_i = {8'h0, b};
        if (ts) task_switch_i = 1'h1;
        else dir_base_wr_i = 1'h1;
        @(negedge mclk_i);
        dir_base_wr_i = 1'h0;
        task_switch_i = 1'h0;
        chk("base", dir_base_o, {8'h0, b[23:12], 12'h000});
    endtask
    task automatic go(input bit v, input logic [15:0] sg,
                      input logic [31:0] of, input bit w, u, s);
        logic [31:0] lin, ip, de, te;
        logic [15:0] ec;
        logic [23:0] pa;
        bit eu, ov, pf;
        int n;
        lin = v ? {12'h000, sg, 4'h0} + of : of;
        eu = (u | v) & !s;
        ip = $urandom;
        delay = $urandom;
        ov = v && lin[31:20] != 0;
        de = rd({dbase[23:12], lin[31:22], 2'h0});
        te = rd({de[23:12], lin[21:12], 2'h0});
        pf = !ov && paging_en_i && (!de[0] || !te[0] || (eu &&
             (!(de[2] & te[2]) || (w && !(de[1] & te[1])))));
        ec = {13'h0, eu, w, de[0] & te[0]};
        pa = paging_en_i ? {te[23:12], lin[11:0]} : lin[23:0];
        {req_v86_i, req_seg_i, req_off_i} = {v, sg, of};
        {req_write_i, req_user_i, req_sys_i, req_ip_i} = {w, u, s, ip};
        req_valid_i = 1'h1;
        @(negedge mclk_i);
        req_valid_i = 1'h0;
        walks = 0;
        for (n = 0; n < 60 && (done_o | fault_o) !== 1'h1; n++)
        begin
            @(negedge mclk_i);
            walks += mem_req_o;
        end
        if (n == 60)
        begin
            err_total++;
            end_of_test();
        end
        chk("fault", fault_o, ov | pf);
        chk("done", done_o, !(ov | pf));
        if (ov | pf)
        begin
            chk("vec", fault_vec_o, ov ? 8'h0D : 8'h0E);
            chk("ip", saved_ip_o, ip);
        end
        if (pf)
        begin
            chk("err", err_code_o, ec);
            chk("faddr", fault_addr_o, lin);
        end
        if (!(ov | pf))
            chk("phys", phys_o, pa);
        if (!(ov | pf) && walks != 0)
        begin
            chk("dacc", rd({dbase[23:12], lin[31:22], 2'h0}) & 32'h20, 32'h20);
            chk("tflag", rd({de[23:12], lin[21:12], 2'h0}) & 32'h60,
                32'h20 | (w ? 32'h40 : te & 32'h40));
        end
    endtask
    //------------------------------------------------------------------
    // Sequence
    //------------------------------------------------------------------
    initial
    begin
        void'($urandom(78));
        repeat (10) @(negedge mclk_i);
        rst_b_i = 1'h1;
        go(0, 16'h0, 32'h12345678, 0, 0, 0);
        go(1, 16'hFFFF, 32'h0000000F, 1, 0, 0);
        go(1, 16'hFFFF, 32'h00000010, 0, 0, 0);
        load_base(0, 24'h001000);
        paging_en_i = 1'h1;
        map(pg[0], 12'hABC, 3'h7, 3'h7);
        map(pg[1], 12'h123, 3'h7, 3'h5);
        map(pg[2], 12'h456, 3'h7, 3'h3);
        map(pg[3], 12'h789, 3'h6, 3'h7);
        map(pg[4], 12'h321, 3'h7, 3'h6);
        map(32'h000B8000, 12'h7F0, 3'h7, 3'h7);
        go(0, 16'h0, 32'h00403ABC, 0, 1, 0);
        chk("miss", walks != 0, 1);
        go(0, 16'h0, 32'h00403FFF, 0, 1, 0);
        chk("hit", walks, 0);
        go(0, 16'h0, 32'h00403004, 1, 1, 0);
        go(0, 16'h0, 32'h00403008, 1, 0, 0);
        chk("hitw", walks, 0);
        for (p = 0; p < 5; p++)
            for (k = 0; k < 8; k++)
                go(0, 16'h0, pg[p] | ($urandom & 32'hFFF), k[0], k[1], k[2]);
        go(1, 16'hB800, 32'h00000123, 0, 0, 0);
        map(pg[0], 12'hDEF, 3'h7, 3'h7);
        load_base(0, 24'h001000);
        go(0, 16'h0, 32'h00403010, 0, 1, 0);
        chk("flush", walks != 0, 1);
        map(pg[0], 12'hDEF, 3'h7, 3'h6);
        load_base(0, 24'h001000);
        go(0, 16'h0, 32'h00403020, 0, 0, 0);
        load_base(1, 24'h002000);
        map(pg[0], 12'h555, 3'h7, 3'h7);
        map(32'h000B8000, 12'h9A0, 3'h7, 3'h7);
        go(0, 16'h0, 32'h00403030, 1, 1, 0);
        chk("tsw", walks != 0, 1);
        for (k = 0; k < 20; k++)
            go(1, 16'hB000 | ($urandom & 16'h0FFF), $urandom & 32'hFFFF,
               $urandom, $urandom, $urandom);
        end_of_test();
    end
endmodule // tb_paging_translation_unit
